// ==== shared/lprs_pkg.sv ====
// Purpose: Shared constants for the linear pixel readout sequencer
// Assumes: One clock (mclk_i) serves as the sensor shift clock
// Notes: Counts are in shift-clock cycles
package lprs_pkg;
	// Geometry of the line
	localparam int LPRS_NUM_SECTIONS = 2;
	localparam int LPRS_PIX_PER_SECTION = 64;
	localparam int LPRS_LINE_PIXELS = 128;
	// Default width of a digitised pixel sample
	localparam int LPRS_SAMPLE_W = 12;
	// Depth of the sample buffer in front of each section output
	localparam int LPRS_FIFO_DEPTH = 16;
	// Edge, counted from the start edge, at which a section goes idle
	localparam int LPRS_END_EDGE = LPRS_PIX_PER_SECTION + 1;
	// Upper limit for the shift clock seen by the sensor
	localparam int LPRS_SHIFT_CLK_MAX_KHZ = 500;
	// Reset values
	localparam logic LPRS_OE_N_RST = 1'b1;
	localparam logic LPRS_CHAIN_RST = 1'b0;
	// Section activity as reported on the status outputs
	typedef enum logic [1:0] {
		LPRS_ST_IDLE = 2'b00,
		LPRS_ST_READOUT = 2'b01,
		LPRS_ST_LAST = 2'b10
	} lprs_state_t;
endpackage

// ==== rtl/lprs_readout.sv ====
// Purpose: Readout sequencer of a two-section, 128-pixel linear light sensor
// Assumes: mclk_i is the shift clock; start inputs are synchronous to it
// Notes: Analog outputs are carried as sample words plus an active-low enable
`timescale 1ns/1ps

// Sample buffer: registered ready toward the front end, show-ahead read side
module lprs_fifo
	import lprs_pkg::*;
#(
	parameter int WIDTH = LPRS_SAMPLE_W,
	parameter int DEPTH = LPRS_FIFO_DEPTH
)
(
	input wire logic mclk_i,               // Shift clock
	input wire logic resetn_i,             // Async reset, active low
	input wire logic in_valid_i,           // Sample offered
	input wire logic [WIDTH-1:0] in_data_i, // Sample word
	output logic in_ready_o,               // Room for one more sample
	output logic out_valid_o,              // Sample available
	output logic [WIDTH-1:0] out_data_o,   // Oldest sample
	input wire logic out_ready_i           // Consumer takes the sample
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic ready_r;

	wire push = in_valid_i & ready_r;
	wire pop = out_ready_i & (count_r != '0);
	wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
	wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;

	assign count_nxt = count_r + CW'(push) - CW'(pop);
	assign in_ready_o = ready_r;
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem[rd_ptr_r];

	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data_i;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			ready_r <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_inc;
			if (pop)
				rd_ptr_r <= rd_ptr_inc;
			count_r <= count_nxt;
			// Ready is registered so the front end sees a clean level
			ready_r <= (count_nxt != FULL_CNT);
		end
	end
endmodule

// Stage chain of one section: a single token walks one stage per clock
module lprs_shift_chain
	import lprs_pkg::*;
#(
	parameter int STAGES = LPRS_PIX_PER_SECTION
)
(
	input wire logic mclk_i,               // Shift clock
	input wire logic resetn_i,             // Async reset, active low
	input wire logic start_i,              // Start taken at this edge
	output logic [STAGES-1:0] token_nxt_o  // Stage contents after this edge
);
	logic [STAGES-1:0] stage_q;
	logic [STAGES-1:0] stage_nxt;

	// A start in mid-sequence clears the later stages, so one token is in flight
	for (genvar b = 0; b < STAGES; b++)
	begin : g_stage
		logic bit_r;

		if (b == 0)
		begin : g_head
			assign stage_nxt[b] = start_i;
		end
		else
		begin : g_body
			assign stage_nxt[b] = ~start_i & stage_q[b-1];
		end

		always_ff @(posedge mclk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				bit_r <= 1'b0;
			else
				bit_r <= stage_nxt[b];
		end

		assign stage_q[b] = bit_r;
	end

	assign token_nxt_o = stage_nxt;
endmodule

// Phase generator: transfer and sense-node reset phases of one section
module lprs_phase_gen
	import lprs_pkg::*;
(
	input wire logic mclk_i,   // Shift clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic active_i, // Section shows a pixel after this edge
	output logic xfer_o,       // Charge transfer phase
	output logic srst_o        // Sense-node reset phase
);
	logic xfer_r;
	logic srst_r;

	// Sense node is reset every cycle, idle or not, so the reference is always fresh
	wire xfer_nxt = active_i;
	wire srst_nxt = 1'b1;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			xfer_r <= 1'b0;
			srst_r <= 1'b0;
		end
		else
		begin
			xfer_r <= xfer_nxt;
			srst_r <= srst_nxt;
		end
	end

	assign xfer_o = xfer_r;
	assign srst_o = srst_r;
endmodule

module lprs_readout
	import lprs_pkg::*;
#(
	parameter int SAMPLE_W = LPRS_SAMPLE_W,
	parameter int FIFO_DEPTH = LPRS_FIFO_DEPTH
)
(
	input wire logic mclk_i,                               // Shift clock
	input wire logic resetn_i,                             // Async reset, active low
	input wire logic section1_start_in_i,                  // Start of section one
	input wire logic section2_start_in_i,                  // Start of section two
	output logic section1_chain_out_o,                     // Chained start, section one
	output logic section2_chain_out_o,                     // Chained start, section two
	output logic [SAMPLE_W-1:0] section1_analog_out_o,     // Pixel level, section one
	output logic section1_analog_oe_n_o,                   // Driver enable, section one
	output logic [SAMPLE_W-1:0] section2_analog_out_o,     // Pixel level, section two
	output logic section2_analog_oe_n_o,                   // Driver enable, section two
	input wire logic [LPRS_NUM_SECTIONS-1:0] sample_valid_i, // Front-end sample offered
	input wire logic [LPRS_NUM_SECTIONS*SAMPLE_W-1:0] sample_data_i, // Samples
	output logic [LPRS_NUM_SECTIONS-1:0] sample_ready_o,   // Buffer has room
	output logic [LPRS_NUM_SECTIONS-1:0] charge_xfer_o,    // Move pixel charge to sense node
	output logic [LPRS_NUM_SECTIONS-1:0] sense_reset_o,    // Sense-node reset phase
	output logic [LPRS_NUM_SECTIONS-1:0] underrun_o,       // No sample when one was due
	output logic [2*LPRS_NUM_SECTIONS-1:0] section_state_o // lprs_state_t per section
);
	localparam int NS = LPRS_NUM_SECTIONS;
	localparam int NP = LPRS_PIX_PER_SECTION;

	wire [NS-1:0] start_in = {section2_start_in_i, section1_start_in_i};
	logic [NS-1:0] chain_q;
	logic [NS-1:0] oe_n_q;
	logic [NS*SAMPLE_W-1:0] level_q;

	for (genvar s = 0; s < NS; s++)
	begin : g_sec
		logic [NP-1:0] token_nxt;
		logic chain_r;
		logic oe_n_r;
		logic [SAMPLE_W-1:0] level_r;
		logic xfer;
		logic srst;
		logic underrun_r;
		logic underrun_nxt;
		lprs_state_t state_r;
		lprs_state_t state_nxt;
		logic fifo_valid;
		logic [SAMPLE_W-1:0] fifo_data;

		// A start edge loads a fresh token and drops any sequence in flight
		wire start_edge = start_in[s];
		lprs_shift_chain #(
			.STAGES(NP)
		) u_chain (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.start_i(start_edge),
			.token_nxt_o(token_nxt)
		);
		// Token in bit k-1 marks the cycle in which pixel k is presented
		wire active_nxt = |token_nxt;
		wire last_nxt = token_nxt[NP-1];
		wire take = active_nxt;
		wire missing = take & ~fifo_valid;

		assign underrun_nxt = missing | (underrun_r & ~start_edge);
		assign state_nxt = last_nxt ? LPRS_ST_LAST :
			(active_nxt ? LPRS_ST_READOUT : LPRS_ST_IDLE);

		lprs_fifo #(
			.WIDTH(SAMPLE_W),
			.DEPTH(FIFO_DEPTH)
		) u_buf (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.in_valid_i(sample_valid_i[s]),
			.in_data_i(sample_data_i[s*SAMPLE_W +: SAMPLE_W]),
			.in_ready_o(sample_ready_o[s]),
			.out_valid_o(fifo_valid),
			.out_data_o(fifo_data),
			.out_ready_i(take)
		);

		lprs_phase_gen u_phase (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.active_i(active_nxt),
			.xfer_o(xfer),
			.srst_o(srst)
		);

		always_ff @(posedge mclk_i or negedge resetn_i)
		begin
			if (!resetn_i)
			begin
				chain_r <= LPRS_CHAIN_RST;
				oe_n_r <= LPRS_OE_N_RST;
				level_r <= '0;
				underrun_r <= 1'b0;
				state_r <= LPRS_ST_IDLE;
			end
			else
			begin
				chain_r <= last_nxt;
				oe_n_r <= ~active_nxt;
				level_r <= (take & fifo_valid) ? fifo_data : '0;
				underrun_r <= underrun_nxt;
				state_r <= state_nxt;
			end
		end

		assign chain_q[s] = chain_r;
		assign oe_n_q[s] = oe_n_r;
		assign level_q[s*SAMPLE_W +: SAMPLE_W] = level_r;
		assign charge_xfer_o[s] = xfer;
		assign sense_reset_o[s] = srst;
		assign underrun_o[s] = underrun_r;
		assign section_state_o[2*s +: 2] = state_r;
	end

	// Serial mode relies on section one's chain being wired to section two's start
	assign section1_chain_out_o = chain_q[0];
	assign section2_chain_out_o = chain_q[1];
	assign section1_analog_oe_n_o = oe_n_q[0];
	assign section2_analog_oe_n_o = oe_n_q[1];
	assign section1_analog_out_o = level_q[0 +: SAMPLE_W];
	assign section2_analog_out_o = level_q[SAMPLE_W +: SAMPLE_W];
endmodule

// ==== testbench/lprs_host.sv ====
// Purpose: Host model that starts lines on the sequencer
// Assumes: Runs on the bench clock
// Notes: Each request gives a start pulse one edge wide
`timescale 1ns/1ps
module lprs_host
(
	input wire logic mclk_i, // Clock
	input wire logic resetn_i, // Reset
	input wire logic go_i, // Line request
	input wire logic par_i, // Parallel wiring
	input wire logic chain1_i, // Chain from section one
	output logic start1_o, // Start one
	output logic start2_o // Start two
);
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			start1_o <= 1'b0;
		else
			start1_o <= go_i;
	end
	// Serial takes section two from the chain, parallel shares the pulse
	assign start2_o = par_i ? start1_o : chain1_i;
endmodule

// ==== testbench/lprs_sva.sv ====
// Purpose: Port checks for the readout sequencer
// Assumes: One clock, reset active low
// Notes: Bound below the module
`timescale 1ns/1ps
module lprs_sva
	import lprs_pkg::*;
(
	input wire logic mclk_i, // Clock
	input wire logic resetn_i, // Reset
	input wire logic section1_start_in_i, // Start one
	input wire logic section2_start_in_i, // Start two
	input wire logic section1_chain_out_o, // Chain one
	input wire logic section2_chain_out_o, // Chain two
	input wire logic section1_analog_oe_n_o, // Enable one
	input wire logic section2_analog_oe_n_o, // Enable two
	input wire logic [LPRS_NUM_SECTIONS-1:0] charge_xfer_o, // Transfer
	input wire logic [LPRS_NUM_SECTIONS-1:0] sense_reset_o // Sense reset
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	a_start_one_runs: assert property (section1_start_in_i |=> !section1_analog_oe_n_o)
		else $error("start one gave no output");
	a_chain_one_late: assert property ($rose(section1_chain_out_o) |->
		$past(section1_start_in_i, 64)) else $error("chain one off time");
	a_chain_two_late: assert property ($rose(section2_chain_out_o) |->
		$past(section2_start_in_i, 64)) else $error("chain two off time");
	a_one_ends_65: assert property (section1_chain_out_o && !section1_start_in_i |=>
		section1_analog_oe_n_o && !section1_chain_out_o) else $error("one not ended");
	a_two_ends_65: assert property (section2_chain_out_o && !section2_start_in_i |=>
		section2_analog_oe_n_o && !section2_chain_out_o) else $error("two not ended");
	a_idle_one_held: assert property (section1_analog_oe_n_o && !section1_start_in_i |=>
		section1_analog_oe_n_o) else $error("one drove while idle");
	a_sense_every: assert property ($past(resetn_i) |-> sense_reset_o == 2'h3)
		else $error("sense reset missing");
	a_xfer_enable: assert property (charge_xfer_o ==
		{!section2_analog_oe_n_o, !section1_analog_oe_n_o}) else $error("transfer off");
	c_serial: cover property ($rose(section2_chain_out_o) && section1_analog_oe_n_o);
	c_parallel: cover property (section1_chain_out_o && section2_chain_out_o);
	c_restart: cover property ($rose(section1_analog_oe_n_o) ##1 !section1_analog_oe_n_o);
endmodule
bind lprs_readout lprs_sva i_lprs_sva (.mclk_i, .resetn_i, .section1_start_in_i,
	.section2_start_in_i, .section1_chain_out_o, .section2_chain_out_o,
	.section1_analog_oe_n_o, .section2_analog_oe_n_o, .charge_xfer_o, .sense_reset_o);

// ==== testbench/lprs_readout_tb.sv ====
// Purpose: Self-checking bench for the readout sequencer
// Assumes: Samples are offered every cycle until the underrun line, which withdraws them
// Notes: Twelve parallel lines, serial line, parallel line with restart, then underrun line
`timescale 1ns/1ps
module lprs_readout_tb;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic go = 1'b0;
	logic par = 1'b0;
	logic [1:0] valid = 2'h0;
	logic [11:0] d1 = 12'h000, d2 = 12'h000, e1 = 12'h000, e2 = 12'h000;
	logic s1, s2, c1, c2, oe1, oe2;
	logic [11:0] a1, a2;
	logic [1:0] rdy, xfer, sr, un;
	logic [3:0] st;
	int err_total = 0, tests_run = 0, cyc = 0;
	always #12.5 mclk_i = ~mclk_i;
	lprs_readout i_lprs_readout (.mclk_i, .resetn_i, .section1_start_in_i(s1),
		.section2_start_in_i(s2), .section1_chain_out_o(c1), .section2_chain_out_o(c2),
		.section1_analog_out_o(a1), .section1_analog_oe_n_o(oe1), .section2_analog_out_o(a2),
		.section2_analog_oe_n_o(oe2), .sample_valid_i(valid), .sample_data_i({d2, d1}),
		.sample_ready_o(rdy), .charge_xfer_o(xfer), .sense_reset_o(sr), .underrun_o(un),
		.section_state_o(st));
	lprs_host i_lprs_host (.mclk_i, .resetn_i, .go_i(go), .par_i(par), .chain1_i(c1),
		.start1_o(s1), .start2_o(s2));
	// Counting words feed both buffers, timeout watch
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (valid[0] && rdy[0])
			d1 <= d1 + 12'h001;
		if (valid[1] && rdy[1])
			d2 <= d2 + 12'h001;
		if (cyc == 3000)
		begin
			err_total = err_total + 1;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check_cycle(input int j, input logic p);
		logic on1, on2;
		on1 = j >= 1 && j <= 64;
		on2 = p ? on1 : j >= 65 && j <= 128;
		chk("control", {4'h0, !on2, !on1, j == 64, p ? j == 64 : j == 128, on2, on1, 2'h3},
			{4'h0, oe2, oe1, c1, c2, xfer, sr});
		chk("state", {8'h0, on2 ? ((p ? j == 64 : j == 128) ? 2'h2 : 2'h1) : 2'h0,
			on1 ? (j == 64 ? 2'h2 : 2'h1) : 2'h0}, {8'h0, st});
		chk("underrun", 12'h000, {10'h0, un});
		if (on1)
		begin
			chk("level1", e1, a1);
			e1 = e1 + 12'h001;
		end
		if (on2)
		begin
			chk("level2", e2, a2);
			e2 = e2 + 12'h001;
		end
	endtask
	task automatic serial_line();
		@(posedge mclk_i);
		par <= 1'b0;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		for (int i = 1; i <= 130; i++)
		begin
			@(posedge mclk_i);
			#1;
			check_cycle(i, 1'b0);
		end
	endtask
	task automatic flush_lines();
		for (int n = 0; n < 12; n++)
		begin
			@(posedge mclk_i);
			par <= 1'b1;
			go <= 1'b1;
			@(posedge mclk_i);
			go <= 1'b0;
			for (int i = 1; i <= 65; i++)
			begin
				@(posedge mclk_i);
				#1;
				check_cycle(i, 1'b1);
			end
		end
	endtask
	task automatic underrun_line();
		@(posedge mclk_i);
		valid <= 2'h0;
		par <= 1'b1;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		for (int i = 1; i <= 65; i++)
		begin
			@(posedge mclk_i);
			#1;
			chk("level1", i <= 16 ? e1 : 12'h000, a1);
			chk("level2", i <= 16 ? e2 : 12'h000, a2);
			chk("underrun", {10'h0, i >= 17 ? 2'h3 : 2'h0}, {10'h0, un});
			if (i <= 16)
			begin
				e1 = e1 + 12'h001;
				e2 = e2 + 12'h001;
			end
		end
	endtask
	task automatic parallel_restart();
		@(posedge mclk_i);
		par <= 1'b1;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		for (int i = 1; i <= 130; i++)
		begin
			@(posedge mclk_i);
			go <= (i == 64);
			#1;
			check_cycle(i > 65 ? i - 65 : i, 1'b1);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge mclk_i);
		resetn_i <= 1'b1;
		valid <= 2'h3;
		repeat (20) @(posedge mclk_i);
		flush_lines();
		serial_line();
		parallel_restart();
		underrun_line();
		complete_run();
	end
endmodule
